//--- logic/deser_check_pkg.sv
/*
 * Constants and types for the deserializer link checker and lane mode block.
 * Assumes a Wishbone slave with 32-bit data and byte address = 4 * register index.
 */
// Notes on behaviour
// R1: once locked in self test, compare against zeros
// R2: show forward errors live on pass output
// R3: error count readable at index forward_error_count
// R4: back-channel CRC check only after lock; link_detect_status[0]
// R5: serializer clears 8-bit CRC count on entry
// R6: serializer counts only in test, keeps result
// R7: pattern generator runs whenever not powered down; code also needs the pattern bit of the test control register
// R8: pattern generator may use configured oscillator
// R9: mode from straps or output_mode_select_b[4:3], output_mode_select_a[5:4]
// R10: auto input lane detect, input_lane_override[4:3] overrides
// R11: each input lane carries 35-bit symbols
// R12: two ports, clock lane, two or four lanes
// R13: unused output lanes held in LP11
// R14: lanes go low power during blanking
// R15: one in, four out: rate times seven
// R16: one in, two out: rate times fourteen
// R17: two in, four out: 50-170 MHz, seven
// R18: two in, two out: 25-48 MHz, fourteen
// R19: dual input lanes merged into one word
// R20: replicate copies primary lanes to second port
// R21: each error drives pass low briefly
// R22: final result held until new test/reset; code also clears it on power-down
// R23: self test enable requests serializer test
// R24: written mode field beats strap value
// R25: new self test clears forward error status
package deser_check_pkg;

    localparam int SYMBOL_BITS = 35;
    localparam int MAX_LANES = 4;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_LINK_DETECT = 8'h0C;
    localparam logic [7:0] IDX_MODE_SEL_B = 8'h23;
    localparam logic [7:0] IDX_FWD_ERRORS = 8'h25;
    localparam logic [7:0] IDX_LANE_OVERRIDE = 8'h34;
    localparam logic [7:0] IDX_MODE_SEL_A = 8'h6A;
    localparam logic [7:0] IDX_TEST_CTRL = 8'h40;
    localparam logic [7:0] IDX_MODE_STATUS = 8'h41;

    // field positions
    localparam int MODE_B_LSB = 3;
    localparam int MODE_A_LSB = 4;
    localparam int LANE_OVR_LSB = 3;
    localparam int CTRL_TEST_BIT = 0;
    localparam int CTRL_PATTERN_BIT = 1;
    localparam int CTRL_OSC_BIT = 2;
    localparam int CTRL_PWRDN_BIT = 3;

    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [2:0] RST_STRAP = 3'h0;

    // input lane override codes
    localparam logic [1:0] OVR_FORCE_ONE = 2'h1;
    localparam logic [1:0] OVR_FORCE_TWO = 2'h2;

    // output lane rate as a multiple of the pixel clock
    localparam logic [3:0] RATE_FOUR_LANES = 4'h7;
    localparam logic [3:0] RATE_TWO_LANES = 4'hE;

    // accepted pixel clock ranges in MHz
    localparam int PCLK_MIN_MHZ = 25;
    localparam int PCLK_MAX_ONE_IN_MHZ = 96;
    localparam int PCLK_MIN_TWO_FOUR_MHZ = 50;
    localparam int PCLK_MAX_TWO_FOUR_MHZ = 170;
    localparam int PCLK_MAX_TWO_TWO_MHZ = 48;

    // output mode codes of the first select
    typedef enum logic [2:0] {
        OUT_FOUR_SINGLE = 3'b000,
        OUT_FOUR_BOTH = 3'b001,
        OUT_TWO_SINGLE = 3'b010,
        OUT_TWO_BOTH = 3'b011
    } out_mode_type;

endpackage : deser_check_pkg

//--- logic/deser_link_check.sv
/*
 * Forward-channel self-test checker, pass pin, back-channel lock gating,
 * input/output lane mode selection, dual-lane merge and output lane states.
 * Assumes lane symbols, lock flags and blanking come from logic on core_clk (the
 * recovered pixel clock); straps, test pin and power-down are asynchronous pins.
 */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module deser_link_check
    import deser_check_pkg::*;
#(
    parameter int ADR_BITS = 10
) (
    input wire logic core_clk,
    input wire logic arst_n,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_BITS-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic selfTestEnablePin,
    input wire logic powerDownPin,
    input wire logic [2:0] strapSelectA,
    input wire logic [2:0] strapSelectB,
    // recovered link
    input wire logic fwdLocked,
    input wire logic backLocked,
    input wire logic [SYMBOL_BITS-1:0] laneSymbol0,
    input wire logic laneValid0,
    input wire logic [SYMBOL_BITS-1:0] laneSymbol1,
    input wire logic laneValid1,
    input wire logic blanking,
    // outputs
    output logic passOut,
    output logic selfTestRequest,
    output logic crcCheckEnable,
    output logic patternActive,
    output logic patternUseOsc,
    output logic [2*SYMBOL_BITS-1:0] mergedWord,
    output logic mergedValid,
    output logic [3:0] laneRateMul,
    output logic [MAX_LANES-1:0] primaryPortLanes,
    output logic primaryClkHs,
    output logic [MAX_LANES-1:0] secondaryPortLanes,
    output logic secondaryClkHs
);

    // pin synchronisers; first stages feed only the second stages
    // power-down may move at any time, so it takes the same two stages
    logic testPinMeta_r, testPinSync_r;
    logic pwrMeta_r, pwrSync_r;
    logic [2:0] strapAMeta_r, strapASync_r, strapBMeta_r, strapBSync_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            testPinMeta_r <= 1'b0;
            testPinSync_r <= 1'b0;
            pwrMeta_r <= 1'b0;
            pwrSync_r <= 1'b0;
            strapAMeta_r <= RST_STRAP;
            strapASync_r <= RST_STRAP;
            strapBMeta_r <= RST_STRAP;
            strapBSync_r <= RST_STRAP;
        end else begin
            testPinMeta_r <= selfTestEnablePin;
            testPinSync_r <= testPinMeta_r;
            pwrMeta_r <= powerDownPin;
            pwrSync_r <= pwrMeta_r;
            strapAMeta_r <= strapSelectA;
            strapASync_r <= strapAMeta_r;
            strapBMeta_r <= strapSelectB;
            strapBSync_r <= strapBMeta_r;
        end
    end

    // straps are caught once, after the synchronisers have filled
    // a strap that moves later is ignored; software rewrites the mode
    logic [1:0] strapWait_r;
    logic [2:0] strapA_r, strapB_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            strapWait_r <= 2'h0;
            strapA_r <= RST_STRAP;
            strapB_r <= RST_STRAP;
        end else if (strapWait_r != 2'h3) begin
            strapWait_r <= strapWait_r + 2'h1;
            strapA_r <= strapASync_r; // R9
            strapB_r <= strapBSync_r;
        end
    end

    // register file
    // a held strobe is not taken twice: the pending ack masks it
    logic [7:0] modeSelB_r, modeSelA_r, laneOvr_r, testCtrl_r;
    logic modeBWritten_r, modeAWritten_r;
    logic busReq;
    logic [7:0] regIdx;

    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign regIdx = wb_adr_i[9:2];

    // writes take effect on the ack edge; low byte lane carries all fields
    // with the low byte lane off nothing changes, not even a written flag
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            modeSelB_r <= RST_REG;
            modeSelA_r <= RST_REG;
            laneOvr_r <= RST_REG;
            testCtrl_r <= RST_REG;
            modeBWritten_r <= 1'b0;
            modeAWritten_r <= 1'b0;
        end else if (busReq && wb_we_i && wb_sel_i[0]) begin
            unique case (regIdx)
                IDX_MODE_SEL_B: begin
                    modeSelB_r <= wb_dat_i[7:0];
                    modeBWritten_r <= 1'b1; // R24
                end
                IDX_MODE_SEL_A: begin
                    modeSelA_r <= wb_dat_i[7:0];
                    modeAWritten_r <= 1'b1; // R24
                end
                IDX_LANE_OVERRIDE: laneOvr_r <= wb_dat_i[7:0];
                IDX_TEST_CTRL: testCtrl_r <= wb_dat_i[7:0];
                default: ; // unmapped or read-only: write ignored
            endcase
        end
    end

    // mode decode: written register field wins over strap
    // once written, a field stays in force until reset
    logic [2:0] outCode;
    logic portSecondary, replicate, fourLanes, twoInLanes;
    logic sawLane1_r;

    always_comb begin
        if (modeAWritten_r) begin
            outCode = {1'b0, modeSelA_r[MODE_A_LSB+1 -: 2]}; // R9 R24
        end else if (strapA_r[2]) begin
            outCode = OUT_FOUR_SINGLE; // reserved strap codes fall back
        end else begin
            outCode = strapA_r; // R9
        end
        if (modeBWritten_r) begin
            portSecondary = modeSelB_r[MODE_B_LSB+1]; // R9 R24
        end else begin
            portSecondary = strapB_r[2];
        end
    end

    assign replicate = (outCode == OUT_FOUR_BOTH) | (outCode == OUT_TWO_BOTH); // R20
    assign fourLanes = (outCode == OUT_FOUR_SINGLE) | (outCode == OUT_FOUR_BOTH); // R12

    // input lane count: auto from activity on the second lane unless overridden
    // lock loss forgets the second lane, so a rebuilt link is detected afresh
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sawLane1_r <= 1'b0;
        end else if (!fwdLocked) begin
            sawLane1_r <= 1'b0;
        end else if (laneValid1) begin
            sawLane1_r <= 1'b1; // R10
        end
    end

    always_comb begin
        unique case (laneOvr_r[LANE_OVR_LSB+1 -: 2])
            OVR_FORCE_ONE: twoInLanes = 1'b0; // R10
            OVR_FORCE_TWO: twoInLanes = 1'b1; // R10
            default: twoInLanes = sawLane1_r;
        endcase
    end

    // self test control and forward-channel checker
    // checking starts one cycle after the run begins, once counts are clear
    logic testOn, testOn_r, testStart;
    logic symErr;
    logic [7:0] errCount_r;
    logic errSeen_r;

    assign testOn = (testPinSync_r | testCtrl_r[CTRL_TEST_BIT]) & ~pwrSync_r;
    assign testStart = testOn & ~testOn_r;
    // any set bit in a 35-bit symbol is a payload error against all zeros
    assign symErr = testOn_r & fwdLocked &
        ((laneValid0 & (|laneSymbol0)) | (twoInLanes & laneValid1 & (|laneSymbol1))); // R1 R11

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            testOn_r <= 1'b0;
        end else begin
            testOn_r <= testOn;
        end
    end

    // count saturates; a new run clears it, power-down clears the result too
    // an error beats a same-cycle clear; a held power-down clears it next cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            errCount_r <= RST_COUNT;
            errSeen_r <= 1'b0;
        end else if (symErr) begin
            errSeen_r <= 1'b1; // R1
            if (errCount_r != 8'hFF) begin
                errCount_r <= errCount_r + 8'h01; // R1 R3
            end
        end else if (testStart || pwrSync_r) begin
            errCount_r <= RST_COUNT; // R25
            errSeen_r <= 1'b0; // R22
        end
    end

    // pass pin: one-cycle low per error while running, held result after
    // the low lasts a whole clock: a flop output cannot change mid-cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            passOut <= 1'b1;
        end else if (testOn_r) begin
            passOut <= ~symErr; // R2 R21
        end else begin
            passOut <= ~errSeen_r; // R22
        end
    end

    // back channel: request and CRC gating
    // CRC checking follows lock one cycle late and stops when lock is lost
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            selfTestRequest <= 1'b0;
            crcCheckEnable <= 1'b0;
        end else begin
            selfTestRequest <= testOn; // R23
            crcCheckEnable <= backLocked; // R4
        end
    end

    // pattern generator steering: runs regardless of input video
    // the oscillator is taken while unlocked, as no pixel clock exists then
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            patternActive <= 1'b0;
            patternUseOsc <= 1'b0;
        end else begin
            patternActive <= testCtrl_r[CTRL_PATTERN_BIT] & ~pwrSync_r &
                ~testCtrl_r[CTRL_PWRDN_BIT]; // R7
            patternUseOsc <= testCtrl_r[CTRL_PATTERN_BIT] &
                (testCtrl_r[CTRL_OSC_BIT] | ~fwdLocked); // R8
        end
    end

    // merge of recovered symbols into one high-speed word
    // one-lane mode zero-fills the upper half so stale lane-1 data never leaks
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mergedWord <= '0;
            mergedValid <= 1'b0;
        end else if (twoInLanes) begin
            mergedWord <= {laneSymbol1, laneSymbol0}; // R19
            mergedValid <= laneValid0 & laneValid1 & fwdLocked;
        end else begin
            mergedWord <= {{SYMBOL_BITS{1'b0}}, laneSymbol0}; // R11
            mergedValid <= laneValid0 & fwdLocked;
        end
    end

    // lane rate: seven times pixel clock on four lanes, fourteen on two
    // only a label for the serial stage; no frequency is measured here
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            laneRateMul <= RATE_FOUR_LANES;
        end else begin
            laneRateMul <= fourLanes ? RATE_FOUR_LANES : RATE_TWO_LANES; // R15 R16 R17 R18
        end
    end

    // output lane states: 1 = high speed, 0 = LP11
    // data lanes wait for mergedValid so no burst starts before data exists
    logic priOn, secOn, burst;

    assign burst = ~blanking & ~pwrSync_r; // R14
    assign priOn = replicate | ~portSecondary;
    assign secOn = replicate | portSecondary; // R20

    genvar ln;
    generate
        for (ln = 0; ln < MAX_LANES; ln++) begin : g_lane
            logic used;
            assign used = fourLanes || (ln < 2); // R12
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    primaryPortLanes[ln] <= 1'b0;
                    secondaryPortLanes[ln] <= 1'b0;
                end else begin
                    primaryPortLanes[ln] <= used & priOn & burst & mergedValid; // R13 R14
                    secondaryPortLanes[ln] <= used & secOn & burst & mergedValid; // R13 R20
                end
            end
        end
    endgenerate

    // clock lanes also drop to low power in blanking
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            primaryClkHs <= 1'b0;
            secondaryClkHs <= 1'b0;
        end else begin
            primaryClkHs <= priOn & burst; // R14
            secondaryClkHs <= secOn & burst; // R20
        end
    end

    // bus answer: ack one cycle after the request, dropped the next cycle
    // unmapped indexes read as zero, so software may probe them safely
    logic [7:0] rdByte;

    always_comb begin
        unique case (regIdx)
            IDX_LINK_DETECT: rdByte = {7'h00, backLocked}; // R4
            IDX_MODE_SEL_B: rdByte = modeSelB_r;
            IDX_FWD_ERRORS: rdByte = errCount_r; // R3
            IDX_LANE_OVERRIDE: rdByte = laneOvr_r;
            IDX_MODE_SEL_A: rdByte = modeSelA_r;
            IDX_TEST_CTRL: rdByte = testCtrl_r;
            IDX_MODE_STATUS: rdByte = {errSeen_r, testOn_r, twoInLanes, replicate,
                portSecondary, outCode};
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? {24'h000000, rdByte} : 32'h0000_0000;
        end
    end

endmodule : deser_link_check

//--- sim/deser_link_check_properties.sv
/* port checker for deser_link_check: bus handshake, pass pin, lane states.
   assumes one clock domain and straps settled before reset release */
`timescale 1ns/1ps
module deser_link_check_properties
    import deser_check_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic powerDownPin,
    input wire logic fwdLocked,
    input wire logic backLocked,
    input wire logic [SYMBOL_BITS-1:0] laneSymbol0,
    input wire logic laneValid0,
    input wire logic blanking,
    input wire logic passOut,
    input wire logic selfTestRequest,
    input wire logic crcCheckEnable,
    input wire logic [3:0] laneRateMul,
    input wire logic [MAX_LANES-1:0] primaryPortLanes,
    input wire logic primaryClkHs,
    input wire logic [MAX_LANES-1:0] secondaryPortLanes,
    input wire logic secondaryClkHs
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // a request still waiting for its answer
    sequence wbReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // a nonzero symbol seen while the test runs on a locked link
    sequence errSym;
        selfTestRequest && fwdLocked && laneValid0 && laneSymbol0 != '0;
    endsequence
    // quiet stretch: no test and no power down for five cycles
    sequence quiet;
        (!selfTestRequest && !powerDownPin)[*5];
    endsequence
    chk_ack_answer: assert property (wbReq |=> wb_ack_o)
        else $error("bus answer missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer too long");
    chk_crc_gate: assert property (!backLocked |=> !crcCheckEnable)
        else $error("crc check before lock");
    chk_crc_start: assert property ($rose(backLocked) |=> crcCheckEnable)
        else $error("crc check not started");
    chk_pass_pulse: assert property (errSym |=> !passOut)
        else $error("error not flagged on pass");
    chk_pass_hold: assert property (quiet |-> $stable(passOut))
        else $error("pass result not held");
    chk_four_rate: assert property ((primaryPortLanes[3] || secondaryPortLanes[3])
        |-> laneRateMul == RATE_FOUR_LANES)
        else $error("four lanes at wrong rate");
    chk_two_lp11: assert property (laneRateMul == RATE_TWO_LANES |->
        primaryPortLanes[3:2] == 2'h0 && secondaryPortLanes[3:2] == 2'h0)
        else $error("unused lane not low power");
    chk_blank_lp: assert property (blanking |=> !primaryClkHs && !secondaryClkHs
        && primaryPortLanes == '0 && secondaryPortLanes == '0)
        else $error("lanes high speed in blanking");
    chk_copy_port: assert property (primaryClkHs && secondaryClkHs
        |-> secondaryPortLanes == primaryPortLanes)
        else $error("replica differs");
endmodule : deser_link_check_properties

bind deser_link_check deser_link_check_properties deser_link_check_properties_inst (
    .core_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .powerDownPin, .fwdLocked,
    .backLocked, .laneSymbol0, .laneValid0, .blanking, .passOut, .selfTestRequest,
    .crcCheckEnable, .laneRateMul, .primaryPortLanes, .primaryClkHs,
    .secondaryPortLanes, .secondaryClkHs
);

//--- sim/serializer_model.sv
/* remote serializer model: link lock, lane symbols, back-channel crc tally.
   assumes the bench supplies payloads and commands each injected error */
`timescale 1ns/1ps
module serializer_model
    import deser_check_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic testReq,
    input wire logic errInject,
    input wire logic twoLanes,
    input wire logic [SYMBOL_BITS-1:0] payload0,
    input wire logic [SYMBOL_BITS-1:0] payload1,
    output logic fwdLocked,
    output logic backLocked,
    output logic [SYMBOL_BITS-1:0] laneSymbol0,
    output logic laneValid0,
    output logic [SYMBOL_BITS-1:0] laneSymbol1,
    output logic laneValid1,
    output logic [7:0] crcErrCount
);
    logic [3:0] lockCnt_r;
    logic testReq_r;
    // forward lock first, back channel later, as after a real power-up
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) lockCnt_r <= 4'h0;
        else if (lockCnt_r != 4'hF) lockCnt_r <= lockCnt_r + 4'h1;
    end
    assign fwdLocked = lockCnt_r > 4'h3;
    assign backLocked = lockCnt_r > 4'h7;
    assign laneValid0 = fwdLocked;
    assign laneValid1 = fwdLocked & twoLanes;
    // 35-bit symbols; zeros in test; an idle lane toggles so stale data never matches
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            laneSymbol0 <= '0;
            laneSymbol1 <= '0;
        end else begin
            laneSymbol0 <= testReq ? {34'h0, errInject} : payload0;
            laneSymbol1 <= !twoLanes ? ~laneSymbol1 : (testReq ? '0 : payload1);
        end
    end
    // crc tally restarts on test entry and freezes outside test
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            testReq_r <= 1'h0;
            crcErrCount <= 8'h00;
        end else begin
            testReq_r <= testReq;
            if (testReq && !testReq_r) crcErrCount <= 8'h00;
            else if (testReq && backLocked && errInject) crcErrCount <= crcErrCount + 8'h01;
        end
    end
endmodule : serializer_model

//--- sim/deser_link_check_tb.sv
/* self-checking bench for deser_link_check against the serializer model.
   assumes 100 MHz clock, byte address = 4 * index, straps at codes 2 and 4 */
`timescale 1ns/1ps
module deser_link_check_tb
    import deser_check_pkg::*;
;
    logic core_clk = 1'h0;
    logic arst_n = 1'h0;
    logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0, testPin = 1'h0, pdPin = 1'h0;
    logic blanking = 1'h0, errInject = 1'h0, twoLanes = 1'h0, wbAck;
    logic [9:0] wbAdr = 10'h000;
    logic [31:0] wbDatI = 32'h0, wbDatO, rd;
    logic [SYMBOL_BITS-1:0] pay0 = '0, pay1 = '0, sym0, sym1;
    logic fwdLocked, backLocked, val0, val1, passOut, testReq, mergedValid, priClk, secClk;
    logic patAct, patOsc;
    logic [2*SYMBOL_BITS-1:0] merged;
    logic [3:0] rateMul, priLanes, secLanes, wbSel = 4'h0;
    logic [2:0] strapA = 3'h2, strapB = 3'h4;
    logic [7:0] idxList [5] = '{IDX_MODE_SEL_B, IDX_LANE_OVERRIDE, IDX_MODE_SEL_A, IDX_FWD_ERRORS,
        8'h50};
    int failCount = 0, nCompared = 0, seed = 30930, cycles = 0, nErr;

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    deser_link_check deser_link_check_inst (.core_clk(core_clk), .arst_n(arst_n),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .selfTestEnablePin(testPin),
        .powerDownPin(pdPin), .strapSelectA(strapA), .strapSelectB(strapB), .fwdLocked(fwdLocked),
        .backLocked(backLocked), .laneSymbol0(sym0), .laneValid0(val0), .laneSymbol1(sym1),
        .laneValid1(val1), .blanking(blanking), .passOut(passOut), .selfTestRequest(testReq),
        .crcCheckEnable(), .patternActive(patAct), .patternUseOsc(patOsc), .mergedWord(merged),
        .mergedValid(mergedValid), .laneRateMul(rateMul), .primaryPortLanes(priLanes),
        .primaryClkHs(priClk), .secondaryPortLanes(secLanes), .secondaryClkHs(secClk));

    serializer_model serializer_model_inst (.core_clk(core_clk), .arst_n(arst_n),
        .testReq(testReq), .errInject(errInject), .twoLanes(twoLanes), .payload0(pay0),
        .payload1(pay1), .fwdLocked(fwdLocked), .backLocked(backLocked), .laneSymbol0(sym0),
        .laneValid0(val0), .laneSymbol1(sym1), .laneValid1(val1), .crcErrCount());

    task automatic check(input logic [69:0] got, input logic [69:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // one classic cycle, held until ack is sampled high
    task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge core_clk);
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbSel <= 4'hF;
        wbAdr <= {idx, 2'h0};
        wbDatI <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'h1 && n < 20);
        rd = wbDatO;
        check(n < 20, 1, "bus answer");
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
    endtask : wbXfer

    // expected {secondary clock, primary clock, secondary lanes, primary lanes}
    function automatic logic [9:0] lanesExp(input int m);
        logic [3:0] used;
        logic p, s;
        used = (m % 4 < 2) ? 4'hF : 4'h3;
        p = (m != 4);
        s = (m == 4) || (m % 2 == 1);
        return {s, p, s ? used : 4'h0, p ? used : 4'h0};
    endfunction : lanesExp

    // hang guard, far above the fewer than two hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'h1;
        repeat (12) @(posedge core_clk);
        foreach (idxList[i]) begin
            wbXfer(1'h0, idxList[i], 8'h00);
            check(rd, 0, "reset value");
        end
        wbXfer(1'h1, IDX_FWD_ERRORS, 8'(SYMBOL_BITS'($random(seed))));
        wbXfer(1'h0, IDX_FWD_ERRORS, 8'h00);
        check(rd, 0, "read-only count");
        wbXfer(1'h0, IDX_LINK_DETECT, 8'h00);
        check(rd, 1, "link detect");
        check(rateMul, 14, "strap rate");
        check({secClk, priClk, secLanes, priLanes}, 10'h230, "strap lanes");
        for (int t = 0; t < 2; t++) begin
            nErr = t ? 0 : 1 + ($unsigned($random(seed)) % 4);
            testPin <= 1'h1;
            repeat (5) @(posedge core_clk);
            check(testReq, 1, "test request");
            for (int e = 0; e < nErr; e++) begin
                errInject <= 1'h1;
                @(posedge core_clk);
                errInject <= 1'h0;
                repeat (2) @(posedge core_clk);
                check(passOut, 0, "error pulse");
                @(posedge core_clk);
                check(passOut, 1, "pulse ends");
            end
            testPin <= 1'h0;
            repeat (8) @(posedge core_clk);
            check(passOut, nErr == 0, "pass held");
            wbXfer(1'h0, IDX_FWD_ERRORS, 8'h00);
            check(rd, nErr, "error count");
        end
        pay0 <= SYMBOL_BITS'({$random(seed), $random(seed)});
        for (int m = 0; m < 5; m++) begin
            wbXfer(1'h1, IDX_MODE_SEL_A, 8'(m % 4) << MODE_A_LSB);
            wbXfer(1'h1, IDX_MODE_SEL_B, (m == 4) ? 8'h10 : 8'h00);
            repeat (3) @(posedge core_clk);
            check(rateMul, (m % 4 < 2) ? 7 : 14, "lane rate");
            check({secClk, priClk, secLanes, priLanes}, lanesExp(m), "lanes");
        end
        blanking <= 1'h1;
        repeat (2) @(posedge core_clk);
        check({secClk, priClk, secLanes, priLanes}, 0, "blanking");
        blanking <= 1'h0;
        twoLanes <= 1'h1;
        for (int c = 0; c < 3; c++) begin
            pay0 <= SYMBOL_BITS'({$random(seed), $random(seed)});
            pay1 <= SYMBOL_BITS'({$random(seed), $random(seed)});
            wbXfer(1'h1, IDX_LANE_OVERRIDE, 8'(c) << LANE_OVR_LSB);
            repeat (4) @(posedge core_clk);
            check(merged, {(c == 1) ? 35'h0 : pay1, pay0}, "merged word");
            check(mergedValid, 1, "merged valid");
        end
        wbXfer(1'h1, IDX_TEST_CTRL, 8'h06);
        repeat (3) @(posedge core_clk);
        check({patAct, patOsc}, 2'h3, "pattern on");
        pdPin <= 1'h1;
        repeat (5) @(posedge core_clk);
        check({patAct, secClk, secLanes, priClk, priLanes}, 0, "power down");
        print_verdict();
    end
endmodule : deser_link_check_tb
